// file: verilog/blcb_pkg.sv
// Overview of operation
// - carry-and-bit sets carry to carry AND the addressed bit, 2 bytes, 2 cycles.
// - opcode 10110000 ands carry with the inverted bit, bit unchanged, 2 bytes, 2 cycles.
// - compare-jump steps pc by 3, then adds the signed last byte when operands differ.
// - compare-jump sets carry when dest is unsigned-below src, else clears it, no operand written.
// - compare-jump has four forms: acc/direct, acc/immediate, register/immediate, indirect/immediate.
// - every compare-jump form is three bytes and finishes in two cycles.
// - opcode 10111rrr compares working register rrr against immediate data.
// - opcode 1011011i compares the ram byte pointed to by pointer register i.
// - clear-accumulator zeroes the accumulator, flags untouched, 1 byte, 1 cycle.
// - clear-bit zeroes the carry or a direct bit, other flags untouched; bit form 2 bytes, 1 cycle.
// - the carry-and source is a directly addressed bit only.
`default_nettype none
package blcb_pkg;
  // opcodes and match masks
  localparam logic [7:0] OPC_AND_BIT = 8'h82;
  localparam logic [7:0] OPC_AND_NBIT = 8'hb0;
  localparam logic [7:0] OPC_CJ_A_IMM = 8'hb4;
  localparam logic [7:0] OPC_CJ_A_DIR = 8'hb5;
  localparam logic [7:0] OPC_CJ_IND = 8'hb6;
  localparam logic [7:0] MASK_CJ_IND = 8'hfe;
  localparam logic [7:0] OPC_CJ_REG = 8'hb8;
  localparam logic [7:0] MASK_CJ_REG = 8'hf8;
  localparam logic [7:0] OPC_ZERO_A = 8'he4;
  localparam logic [7:0] OPC_ZERO_C = 8'hc3;
  localparam logic [7:0] OPC_ZERO_BIT = 8'hc2;
  // instruction lengths in bytes, as pc steps
  localparam logic [15:0] LEN_1 = 16'h0001;
  localparam logic [15:0] LEN_2 = 16'h0002;
  localparam logic [15:0] LEN_3 = 16'h0003;
  // cycle counts
  localparam logic [1:0] CYC_1 = 2'h1;
  localparam logic [1:0] CYC_2 = 2'h2;
  // reset values
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [7:0] BYTE_RST = 8'h00;

  typedef enum logic [3:0] {
    K_NONE = 4'h0,
    K_AND_BIT = 4'h1,
    K_AND_NBIT = 4'h2,
    K_CJ_A_DIR = 4'h3,
    K_CJ_A_IMM = 4'h4,
    K_CJ_REG = 4'h5,
    K_CJ_IND = 4'h6,
    K_ZERO_A = 4'h7,
    K_ZERO_C = 4'h8,
    K_ZERO_BIT = 4'h9
  } blcb_kind_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b10
  } blcb_state_e;

  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] op1;
    logic [7:0] op2;
  } blcb_instr_s;

  typedef struct packed {
    blcb_kind_e kind;
    logic [15:0] len;
    logic [1:0] cyc;
  } blcb_dec_s;

  typedef struct packed {
    logic bit_rd;
    logic byte_rd;
    logic indirect;
    logic [7:0] addr;
  } blcb_rdreq_s;

  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic val;
  } blcb_bitwr_s;
endpackage
`default_nettype wire

// file: verilog/blcb_decode.sv
`timescale 1ns/1ps
`default_nettype none
module blcb_decode (
  // raw opcode byte
  input wire logic [7:0] opcode,
  // decoded class, length and cycle count
  output wire blcb_pkg::blcb_dec_s dec
);
  // one match wire per instruction; masks keep each form unique
  wire logic m_and = opcode == blcb_pkg::OPC_AND_BIT;
  wire logic m_andn = opcode == blcb_pkg::OPC_AND_NBIT;
  wire logic m_cjd = opcode == blcb_pkg::OPC_CJ_A_DIR;
  wire logic m_cji = opcode == blcb_pkg::OPC_CJ_A_IMM;
  wire logic m_cjr = (opcode & blcb_pkg::MASK_CJ_REG)
    == blcb_pkg::OPC_CJ_REG;
  wire logic m_cjn = (opcode & blcb_pkg::MASK_CJ_IND)
    == blcb_pkg::OPC_CJ_IND;
  wire logic m_cla = opcode == blcb_pkg::OPC_ZERO_A;
  wire logic m_clc = opcode == blcb_pkg::OPC_ZERO_C;
  wire logic m_clb = opcode == blcb_pkg::OPC_ZERO_BIT;
  wire logic m_cj = m_cjd | m_cji | m_cjr | m_cjn;
  wire logic m_and_any = m_and | m_andn;

  // class select
  assign dec.kind = m_and ? blcb_pkg::K_AND_BIT :
                    m_andn ? blcb_pkg::K_AND_NBIT :
                    m_cjd ? blcb_pkg::K_CJ_A_DIR :
                    m_cji ? blcb_pkg::K_CJ_A_IMM :
                    m_cjr ? blcb_pkg::K_CJ_REG :
                    m_cjn ? blcb_pkg::K_CJ_IND :
                    m_cla ? blcb_pkg::K_ZERO_A :
                    m_clc ? blcb_pkg::K_ZERO_C :
                    m_clb ? blcb_pkg::K_ZERO_BIT : blcb_pkg::K_NONE;

  // byte length and cycle count of each class
  assign dec.len = m_cj ? blcb_pkg::LEN_3 :
                   (m_and_any | m_clb) ? blcb_pkg::LEN_2 :
                   blcb_pkg::LEN_1;
  assign dec.cyc = (m_cj | m_and_any) ? blcb_pkg::CYC_2 :
                   blcb_pkg::CYC_1;
endmodule
`default_nettype wire

// file: verilog/blcb_exec.sv
`timescale 1ns/1ps
`default_nettype none
module blcb_exec (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // instruction issue from the core
  input wire logic issue,
  input wire blcb_pkg::blcb_instr_s instr,
  input wire logic [15:0] pc_in,
  // architectural state presented by the core
  input wire logic [7:0] acc_in,
  input wire logic carry_in,
  input wire logic [7:0][7:0] wreg_in,
  // read answers, valid while a read request stands
  input wire logic bit_rd_data,
  input wire logic [7:0] byte_rd_data,
  // read request to the core
  output var blcb_pkg::blcb_rdreq_s rd_req_r,
  // status
  output var logic busy_r,
  output var logic done_r,
  output var logic illegal_r,
  // results, each valid with its write enable
  output var logic pc_we_r,
  output var logic [15:0] pc_out_r,
  output var logic acc_we_r,
  output var logic [7:0] acc_out_r,
  output var logic carry_we_r,
  output var logic carry_out_r,
  output var blcb_pkg::blcb_bitwr_s bit_wr_r
);
  blcb_pkg::blcb_dec_s dec;
  blcb_pkg::blcb_state_e state_r;
  blcb_pkg::blcb_kind_e kind_r;
  blcb_pkg::blcb_instr_s instr_r;
  logic [15:0] pc_base_r;
  logic [7:0] acc_l_r;
  logic [7:0] reg_l_r;
  logic carry_l_r;

  blcb_decode u_dec (
    .opcode(instr.opcode),
    .dec(dec)
  );

  // issue acceptance; a new issue while busy is ignored
  wire logic take = issue && (state_r == blcb_pkg::ST_IDLE);
  wire logic one_cyc = dec.cyc == blcb_pkg::CYC_1;
  wire logic in_exec = state_r == blcb_pkg::ST_EXEC;
  wire logic is_and = (dec.kind == blcb_pkg::K_AND_BIT) ||
                      (dec.kind == blcb_pkg::K_AND_NBIT);
  wire logic is_ind = dec.kind == blcb_pkg::K_CJ_IND;
  wire logic is_dir = dec.kind == blcb_pkg::K_CJ_A_DIR;
  wire logic [7:0] ptr_val = wreg_in[{2'b00, instr.opcode[0]}];

  // read request: the carry-and source is only ever a direct bit
  wire blcb_pkg::blcb_rdreq_s rdreq_nxt;
  assign rdreq_nxt.bit_rd = is_and;
  assign rdreq_nxt.byte_rd = is_dir | is_ind;
  assign rdreq_nxt.indirect = is_ind;
  assign rdreq_nxt.addr = is_ind ? ptr_val : instr.op1;

  // single-cycle clears; pc steps by the instruction length
  wire logic [15:0] pc_one_nxt = pc_in + dec.len;
  wire logic zero_a = dec.kind == blcb_pkg::K_ZERO_A;
  wire logic zero_c = dec.kind == blcb_pkg::K_ZERO_C;
  wire logic zero_b = dec.kind == blcb_pkg::K_ZERO_BIT;

  // compare operands; neither is ever written back
  wire logic [7:0] cj_dest =
    (kind_r == blcb_pkg::K_CJ_IND) ? byte_rd_data :
    (kind_r == blcb_pkg::K_CJ_REG) ? reg_l_r : acc_l_r;
  wire logic [7:0] cj_src =
    (kind_r == blcb_pkg::K_CJ_A_DIR) ? byte_rd_data : instr_r.op1;
  wire logic cj_ne = cj_dest != cj_src;
  wire logic cj_lt = cj_dest < cj_src;
  wire logic [15:0] rel_sext = {{8{instr_r.op2[7]}}, instr_r.op2};
  wire logic [15:0] pc_seq = pc_base_r + blcb_pkg::LEN_3;
  wire logic [15:0] pc_jmp = pc_seq + rel_sext;
  wire logic is_cj_r = (kind_r == blcb_pkg::K_CJ_A_DIR) ||
                       (kind_r == blcb_pkg::K_CJ_A_IMM) ||
                       (kind_r == blcb_pkg::K_CJ_REG) ||
                       (kind_r == blcb_pkg::K_CJ_IND);

  // second-cycle results
  wire logic and_src = (kind_r == blcb_pkg::K_AND_NBIT) ?
                       ~bit_rd_data : bit_rd_data;
  wire logic carry_ex_nxt = is_cj_r ? cj_lt :
                            (carry_l_r & and_src);
  wire logic [15:0] pc_ex_nxt = !is_cj_r ? pc_base_r + blcb_pkg::LEN_2 :
                                cj_ne ? pc_jmp : pc_seq;

  // sequencer and operand latches taken at issue
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_r <= blcb_pkg::ST_IDLE;
      kind_r <= blcb_pkg::K_NONE;
      instr_r <= '0;
      pc_base_r <= blcb_pkg::PC_RST;
      acc_l_r <= blcb_pkg::BYTE_RST;
      reg_l_r <= blcb_pkg::BYTE_RST;
      carry_l_r <= 1'b0;
    end else if (take) begin
      state_r <= one_cyc ? blcb_pkg::ST_IDLE : blcb_pkg::ST_EXEC;
      kind_r <= dec.kind;
      instr_r <= instr;
      pc_base_r <= pc_in;
      acc_l_r <= acc_in;
      reg_l_r <= wreg_in[instr.opcode[2:0]];
      carry_l_r <= carry_in;
    end else if (in_exec) begin
      state_r <= blcb_pkg::ST_IDLE;
    end
  end

  // request and status flags
  always_ff @(posedge mclk) begin
    if (srst) begin
      rd_req_r <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      illegal_r <= 1'b0;
    end else begin
      rd_req_r <= (take && !one_cyc) ? rdreq_nxt : '0;
      busy_r <= take && !one_cyc;
      done_r <= (take && one_cyc) || in_exec;
      illegal_r <= take && (dec.kind == blcb_pkg::K_NONE);
    end
  end

  // pc result, written on every completion
  always_ff @(posedge mclk) begin
    if (srst) begin
      pc_we_r <= 1'b0;
      pc_out_r <= blcb_pkg::PC_RST;
    end else begin
      pc_we_r <= (take && one_cyc) || in_exec;
      if (take && one_cyc) begin
        pc_out_r <= pc_one_nxt;
      end else if (in_exec) begin
        pc_out_r <= pc_ex_nxt;
      end
    end
  end

  // accumulator, carry and bit writes; flags not named stay untouched
  always_ff @(posedge mclk) begin
    if (srst) begin
      acc_we_r <= 1'b0;
      acc_out_r <= blcb_pkg::BYTE_RST;
      carry_we_r <= 1'b0;
      carry_out_r <= 1'b0;
      bit_wr_r <= '0;
    end else begin
      acc_we_r <= take && zero_a;
      acc_out_r <= blcb_pkg::BYTE_RST;
      carry_we_r <= (take && zero_c) || in_exec;
      carry_out_r <= in_exec ? carry_ex_nxt : 1'b0;
      bit_wr_r.we <= take && zero_b;
      bit_wr_r.addr <= instr.op1;
      bit_wr_r.val <= 1'b0;
    end
  end

  // checks on the outputs against their causes
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);

  property p_zero_a;
    take && zero_a |=> done_r && acc_we_r && (acc_out_r == 8'h00)
      && !carry_we_r && (pc_out_r == $past(pc_in) + 16'h0001);
  endproperty
  a_zero_a: assert property (p_zero_a)
    else $error("clear accumulator result wrong");

  property p_zero_c;
    take && zero_c |=> done_r && carry_we_r && !carry_out_r && !acc_we_r
      && !bit_wr_r.we;
  endproperty
  a_zero_c: assert property (p_zero_c)
    else $error("clear carry result wrong");

  property p_zero_bit;
    take && zero_b |=> done_r && bit_wr_r.we && !bit_wr_r.val
      && (bit_wr_r.addr == $past(instr.op1)) && !carry_we_r
      && (pc_out_r == $past(pc_in) + 16'h0002);
  endproperty
  a_zero_bit: assert property (p_zero_bit)
    else $error("clear bit result wrong");

  property p_and;
    take && (dec.kind == blcb_pkg::K_AND_BIT) |=> busy_r && !done_r
      ##1 done_r && carry_we_r
      && (carry_out_r == ($past(carry_in, 2) & $past(bit_rd_data)));
  endproperty
  a_and: assert property (p_and)
    else $error("carry and bit result wrong");

  property p_anln;
    take && (dec.kind == blcb_pkg::K_AND_NBIT) |-> ##2 done_r
      && !bit_wr_r.we
      && (carry_out_r == ($past(carry_in, 2) & ~$past(bit_rd_data)));
  endproperty
  a_anln: assert property (p_anln)
    else $error("carry and inverted bit result wrong");

  property p_and_src;
    take && is_and |=> rd_req_r.bit_rd && !rd_req_r.byte_rd
      && (rd_req_r.addr == $past(instr.op1));
  endproperty
  a_and_src: assert property (p_and_src)
    else $error("carry and source not a direct bit");

  property p_cj_imm;
    take && (dec.kind == blcb_pkg::K_CJ_A_IMM) |-> ##2 done_r
      && (carry_out_r == ($past(acc_in, 2) < $past(instr.op1, 2)))
      && (pc_out_r == $past(pc_in, 2) + 16'h0003
        + (($past(acc_in, 2) != $past(instr.op1, 2)) ?
           {{8{$past(instr.op2[7], 2)}}, $past(instr.op2, 2)} : 16'h0000));
  endproperty
  a_cj_imm: assert property (p_cj_imm)
    else $error("compare jump pc or carry wrong");

  property p_cj_shape;
    take && (dec.len == blcb_pkg::LEN_3) |-> (dec.cyc == blcb_pkg::CYC_2)
      ##2 done_r && carry_we_r && !acc_we_r && !bit_wr_r.we;
  endproperty
  a_cj_shape: assert property (p_cj_shape)
    else $error("compare jump length or timing wrong");

  property p_ind_addr;
    take && is_ind |=> rd_req_r.byte_rd && rd_req_r.indirect
      && (rd_req_r.addr == $past(wreg_in[{2'b00, instr.opcode[0]}]));
  endproperty
  a_ind_addr: assert property (p_ind_addr)
    else $error("indirect pointer select wrong");

  property p_reg_dec;
    take && (instr.opcode[7:3] == 5'b10111) |->
      (dec.kind == blcb_pkg::K_CJ_REG) ##1 busy_r;
  endproperty
  a_reg_dec: assert property (p_reg_dec)
    else $error("register compare form not decoded");
endmodule
`default_nettype wire

// file: bench/bit_logic_compare_branch_clear_test.sv
`timescale 1ns/1ps
`default_nettype none
module bit_logic_compare_branch_clear_test;
  logic mclk;
  logic srst;
  logic issue;
  blcb_pkg::blcb_instr_s instr;
  logic [15:0] pc_in;
  logic [7:0] acc_in;
  logic carry_in;
  logic [7:0][7:0] wreg_in;
  logic bit_rd_data;
  logic [7:0] byte_rd_data;
  blcb_pkg::blcb_rdreq_s rd_req_r;
  logic busy_r, done_r, illegal_r, pc_we_r, acc_we_r, carry_we_r, carry_out_r;
  logic [15:0] pc_out_r;
  logic [7:0] acc_out_r;
  blcb_pkg::blcb_bitwr_s bit_wr_r;
  int num_errors;
  int check_count;
  int cyc_seen;
  blcb_pkg::blcb_rdreq_s req_seen;
  logic busy_seen;

  blcb_exec i_blcb_exec (.mclk(mclk), .srst(srst), .issue(issue),
    .instr(instr), .pc_in(pc_in), .acc_in(acc_in), .carry_in(carry_in),
    .wreg_in(wreg_in), .bit_rd_data(bit_rd_data),
    .byte_rd_data(byte_rd_data), .rd_req_r(rd_req_r), .busy_r(busy_r),
    .done_r(done_r), .illegal_r(illegal_r), .pc_we_r(pc_we_r),
    .pc_out_r(pc_out_r), .acc_we_r(acc_we_r), .acc_out_r(acc_out_r),
    .carry_we_r(carry_we_r), .carry_out_r(carry_out_r),
    .bit_wr_r(bit_wr_r));

  // free-running core clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // issue one op, then follow it to its completion cycle
  task automatic run_op(input logic [7:0] opc, input logic [7:0] b1,
                        input logic [7:0] b2);
    @(negedge mclk);
    issue = 1'b1;
    instr = {opc, b1, b2};
    @(negedge mclk);
    issue = 1'b0;
    req_seen = rd_req_r;
    busy_seen = busy_r;
    cyc_seen = 1;
    while (done_r !== 1'b1 && cyc_seen < 5) begin
      @(negedge mclk);
      cyc_seen++;
    end
  endtask

  // judged in the completion cycle, since the pulses stand one cycle only
  task automatic expect_res(input int cyc, input logic [15:0] pc,
      input logic cwe, input logic c, input logic awe, input logic bwe,
      input logic ill);
    chk(done_r, 1'b1);
    chk(cyc_seen, cyc);
    chk(busy_seen, cyc == 2);
    chk(pc_we_r, 1'b1);
    chk(pc_out_r, pc);
    chk(carry_we_r, cwe);
    if (cwe) chk(carry_out_r, c);
    chk(acc_we_r, awe);
    chk(bit_wr_r.we, bwe);
    chk(illegal_r, ill);
  endtask

  // target of a compare-jump: next instruction plus signed displacement
  function automatic logic [15:0] jmp(input logic [7:0] rel, input logic ne);
    return pc_in + 16'h0003 + (ne ? {{8{rel[7]}}, rel} : 16'h0000);
  endfunction

  task automatic t_clear;
    acc_in = 8'h5c;
    carry_in = 1'b1;
    run_op(8'he4, 8'h00, 8'h00);
    expect_res(1, pc_in + 16'h0001, 1'b0, 1'b0, 1'b1,
      1'b0, 1'b0);
    chk(acc_out_r, 8'h00);
    run_op(8'hc3, 8'h00, 8'h00);
    expect_res(1, pc_in + 16'h0001, 1'b1, 1'b0, 1'b0,
      1'b0, 1'b0);
    run_op(8'hc2, 8'h91, 8'h00);
    expect_res(1, pc_in + 16'h0002, 1'b0, 1'b0, 1'b0,
      1'b1, 1'b0);
    chk({bit_wr_r.addr, bit_wr_r.val}, {8'h91, 1'b0});
    $display("test clear done");
  endtask

  // every carry and bit combination, plain and inverted source
  task automatic t_and;
    logic exp;
    for (int k = 0; k < 8; k++) begin
      carry_in = k[0];
      bit_rd_data = k[1];
      exp = k[0] & (k[1] ^ k[2]);
      run_op(k[2] ? 8'hb0 : 8'h82, 8'he7, 8'h00);
      expect_res(2, pc_in + 16'h0002, 1'b1, exp, 1'b0,
        1'b0, 1'b0);
      chk({req_seen.bit_rd, req_seen.byte_rd, req_seen.addr},
        {2'b10, 8'he7});
    end
    $display("test carry and done");
  endtask

  task automatic t_cj_acc;
    acc_in = 8'h34;
    carry_in = 1'b1;
    run_op(8'hb4, 8'h34, 8'hf0);
    expect_res(2, jmp(8'hf0, 1'b0), 1'b1, 1'b0, 1'b0,
      1'b0, 1'b0);
    run_op(8'hb4, 8'h60, 8'hf0);
    expect_res(2, jmp(8'hf0, 1'b1), 1'b1, 1'b1, 1'b0,
      1'b0, 1'b0);
    chk(req_seen.byte_rd | req_seen.bit_rd, 1'b0);
    byte_rd_data = 8'h12;
    run_op(8'hb5, 8'h90, 8'h05);
    expect_res(2, jmp(8'h05, 1'b1), 1'b1, 1'b0, 1'b0,
      1'b0, 1'b0);
    chk({req_seen.byte_rd, req_seen.indirect, req_seen.addr},
      {2'b10, 8'h90});
    $display("test compare accumulator done");
  endtask

  // each working register against 53: below, equal and above all occur
  task automatic t_cj_reg;
    for (int r = 0; r < 8; r++) begin
      wreg_in[r] = 8'h50 + 8'(r);
    end
    for (int r = 0; r < 8; r++) begin
      run_op(8'hb8 | 8'(r), 8'h53, 8'h10);
      expect_res(2, jmp(8'h10, r != 3), 1'b1, r < 3, 1'b0,
        1'b0, 1'b0);
    end
    $display("test compare register done");
  endtask

  task automatic t_cj_ind;
    wreg_in[0] = 8'h20;
    wreg_in[1] = 8'h21;
    byte_rd_data = 8'h80;
    for (int i = 0; i < 2; i++) begin
      run_op(8'hb6 | 8'(i), 8'h7f, 8'h80);
      expect_res(2, jmp(8'h80, 1'b1), 1'b1, 1'b0, 1'b0,
        1'b0, 1'b0);
      chk({req_seen.byte_rd, req_seen.indirect, req_seen.addr},
        {2'b11, 8'h20 + 8'(i)});
    end
    $display("test compare indirect done");
  endtask

  task automatic t_illegal;
    run_op(8'ha5, 8'h00, 8'h00);
    expect_res(1, pc_in + 16'h0001, 1'b0, 1'b0, 1'b0,
      1'b0, 1'b1);
    $display("test illegal done");
  endtask

  // clear ops issued every cycle, then an issue during the exec cycle
  task automatic t_order;
    @(negedge mclk);
    issue = 1'b1;
    instr = {8'he4, 16'h0000};
    @(negedge mclk);
    instr = {8'hc3, 16'h0000};
    chk({done_r, acc_we_r, carry_we_r}, 3'b110);
    @(negedge mclk);
    instr = {8'h82, 16'h0000};
    chk({done_r, acc_we_r, carry_we_r}, 3'b101);
    @(negedge mclk);
    instr = {8'he4, 16'h0000};
    chk(busy_r, 1'b1);
    @(negedge mclk);
    issue = 1'b0;
    chk({done_r, acc_we_r}, 2'b10);
    @(negedge mclk);
    chk(done_r, 1'b0);
    $display("test order done");
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // watchdog: the whole sequence needs well under 200 cycles
  initial begin
    #20000;
    num_errors++;
    final_report();
  end

  initial begin
    num_errors = 0;
    check_count = 0;
    srst = 1'b1;
    issue = 1'b0;
    instr = '0;
    pc_in = 16'h1000;
    acc_in = 8'h00;
    carry_in = 1'b0;
    wreg_in = '0;
    bit_rd_data = 1'b0;
    byte_rd_data = 8'h00;
    repeat (8) @(negedge mclk);
    srst = 1'b0;
    t_clear();
    t_and();
    t_cj_acc();
    t_cj_reg();
    t_cj_ind();
    t_illegal();
    t_order();
    final_report();
  end
endmodule
`default_nettype wire
